/* File: local_bus_consts.vh */
`ifndef LOCAL_BUS_CONSTS_VH
`define LOCAL_BUS_CONSTS_VH

// ************************************************************
// transfer type and size codes
// ************************************************************
`define TT_NORMAL_LAST 2'h2
`define TT_IACK        2'h3
`define SIZ_LONG       2'h0
`define SIZ_BYTE       2'h1
`define SIZ_WORD       2'h2

// ************************************************************
// window bases and masks
// ************************************************************
`define MASK_2M        32'hFFE0_0000
`define MASK_128K      32'hFFFE_0000
`define MASK_256B      32'hFFFF_FF00
`define MASK_4K        32'hFFFF_F000
`define MASK_2K        32'hFFFF_F800
`define MASK_32B       32'hFFFF_FFE0
`define MASK_64K       32'hFFFF_0000
`define ALIAS_BASE     32'h0000_0000
`define ROM_LOW_ALIAS_BIT_BASE      32'hFF80_0000
`define ROM1_BASE      32'hFFA0_0000
`define SRAM_DEF_BASE  32'hFFE0_0000
`define IO_FIRST       32'hFFF0_0000
`define IO_LAST        32'hFFFE_FFFF
`define LOCAL_CONTROL_STATUS_SPACE_BASE      32'hFFF4_0000
`define GLOBAL_CONTROL_STATUS_SPACE_BASE      32'hFFF4_0100
`define CTRL_BASE      32'hFFF4_2000
`define ECC_BASE       32'hFFF4_3000
`define SERIAL_BASE    32'hFFF4_5000
`define LAN_BASE       32'hFFF4_6000
`define SCSI_BASE      32'hFFF4_7000
`define CIO_BASE       32'hFFF5_8000
`define CREG_BASE      32'hFFFB_C000
`define BATTERY_BACKED_RAM_BASE     32'hFFFC_0000
`define VME16_BASE     32'hFFFF_0000

// battery ram sub-window, address bits 15:14
`define BB_FWE_OFF     2'h2
`define BB_FWE_ON      2'h3
`define FLASH_WE_RST   1'b0
`define ALIAS_RST      1'b1

// ************************************************************
// target select indices
// ************************************************************
`define NUM_TGT        17
`define T_ROM_LOW_ALIAS_BIT         0
`define T_ROM1         1
`define T_SRAM         2
`define T_SRAM_MEZZ    3
`define T_DRAM         4
`define T_LOCAL_CONTROL_STATUS_SPACE         5
`define T_GLOBAL_CONTROL_STATUS_SPACE         6
`define T_CTRL         7
`define T_ECC          8
`define T_SERIAL       9
`define T_LAN          10
`define T_SCSI         11
`define T_CIO          12
`define T_CREG         13
`define T_BATTERY_BACKED_RAM        14
`define T_VME16        15
`define T_IACK         16

`endif

/* File: rom_byte_sizer.v */
`timescale 1ns/100ps
`include "local_bus_consts.vh"
module rom_byte_sizer (
	input  wire        clk,
	input  wire        rst_b,
	input  wire        start,
	input  wire        abort,
	input  wire        rd,
	input  wire [1:0]  size,
	input  wire [1:0]  offset,
	input  wire [31:0] wdata,
	input  wire        wr_allow,
	output wire [1:0]  priv_off,
	output wire        priv_rd,
	output wire        priv_wr,
	output wire [7:0]  priv_wdata,
	input  wire [7:0]  priv_rdata,
	input  wire        priv_ack,
	output wire        done,
	output wire [31:0] rdata
);
	reg        busy_r;
	reg [2:0]  left_r;
	reg [1:0]  off_r;
	reg        rd_r;
	reg        allow_r;
	reg [31:0] wdata_r;
	reg [7:0]  wbyte_r;
	reg [31:0] rdata_r;
	reg        done_r;
	wire [1:0] nxt_off;
	wire       byte_ack;
	reg [2:0]  count_nxt;

	// each byte of a blocked flash write completes at once so the bus cycle is not left hanging
	assign byte_ack   = busy_r & (priv_ack | (~rd_r & ~allow_r));
	assign nxt_off    = off_r + 2'h1;
	assign priv_off   = off_r;
	assign priv_rd    = busy_r & rd_r;
	assign priv_wr    = busy_r & ~rd_r & allow_r;
	assign priv_wdata = wbyte_r;
	assign done       = done_r;
	assign rdata      = rdata_r;

	always @* begin
		case (size)
			`SIZ_BYTE: count_nxt = 3'h1;
			`SIZ_WORD: count_nxt = 3'h2;
			default:   count_nxt = 3'h4;
		endcase
	end

	// big-endian lanes: byte offset 0 sits in bits 31:24
	always @(posedge clk) begin
		if (!rst_b) begin
			busy_r  <= 1'b0;
			left_r  <= 3'h0;
			off_r   <= 2'h0;
			rd_r    <= 1'b0;
			allow_r <= 1'b0;
			wdata_r <= 32'h0000_0000;
			wbyte_r <= 8'h00;
			rdata_r <= 32'h0000_0000;
			done_r  <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (abort) begin
				busy_r <= 1'b0;
			end else if (start) begin
				busy_r  <= 1'b1;
				left_r  <= count_nxt;
				off_r   <= offset;
				rd_r    <= rd;
				allow_r <= wr_allow;
				wdata_r <= wdata;
				wbyte_r <= wdata[{~offset, 3'b000} +: 8];
				rdata_r <= 32'h0000_0000;
			end else if (byte_ack) begin
				if (rd_r)
					rdata_r[{~off_r, 3'b000} +: 8] <= priv_rdata;
				off_r   <= nxt_off;
				wbyte_r <= wdata_r[{~nxt_off, 3'b000} +: 8];
				left_r  <= left_r - 3'h1;
				if (left_r == 3'h1) begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
				end
			end
		end
	end
endmodule

/* File: local_bus_address_decoder.v */
// Overview of operation
// RULE1: transfer types 0, 1 and 2 are decoded through the normal memory map.
// RULE2: onboard logic answers normal cycles and interrupt acknowledge cycles.
// RULE3: while the alias bit is high, the first boot block also answers at 0-1FFFFF.
// RULE4: every reset forces the alias bit to one.
// RULE5: software clears the alias bit before mapping memory at the bottom 2 MB.
// RULE6: unclaimed ranges go unanswered and time out when the timer is enabled.
// RULE7: reserved windows never acknowledge; enabled timer ends them with error.
// RULE8: ecc controller windows answer only when the ecc mezzanine is fitted.
// RULE9: local csr writes must be 32 bits; narrower writes end with error.
// RULE10: global csr writes and all csr reads accept 8, 16 or 32 bits.
// RULE11: software should read the interrupt vector with byte reads.
// RULE12: masters reach the serial controllers with byte cycles only.
// RULE13: lan port commands are two 16-bit writes, upper word first.
// RULE14: boot rom and flash accesses are split into 8-bit private bus cycles.
// RULE15: sram is 128 KB onboard, or 2 MB with mezzanine and onboard disabled.
// RULE16: FFF00000-FFFEFFFF is the local i/o area, split into peripheral windows.
// RULE17: software maps onboard i/o as cache-inhibited and serialized.
// RULE18: both battery ram aliases reach it, and also disable or enable flash writes.
// RULE19: at most one target select per access, held until that target terminates.
`timescale 1ns/100ps
`include "local_bus_consts.vh"
module local_bus_address_decoder #(
	parameter TIMEOUT_CYCLES = 256,
	parameter DRAM_SIZE_LOG2 = 22
) (
	input  wire                  clk,
	input  wire                  rst_b,
	input  wire                  bus_start,
	input  wire [31:0]           bus_addr,
	input  wire [1:0]            transfer_type_code,
	input  wire                  bus_read,
	input  wire [1:0]            bus_size,
	input  wire [31:0]           bus_wdata,
	input  wire                  bus_timer_en,
	input  wire [31:0]           dram_base,
	input  wire                  dram_en,
	input  wire [31:0]           sram_base,
	input  wire                  sram_en,
	input  wire                  rom_alias_clear,
	input  wire                  ecc_mezz_fitted,
	input  wire                  sram_mezz_fitted,
	input  wire                  tgt_ack,
	input  wire [31:0]           tgt_rdata,
	input  wire [7:0]            rom_rdata,
	input  wire                  rom_byte_ack,
	output wire [`NUM_TGT-1:0]   target_sel,
	output wire                  bus_ack,
	output wire                  transfer_error_ack,
	output wire [31:0]           bus_rdata,
	output wire                  rom_low_alias_bit,
	output wire                  flash_write_en,
	output wire [31:0]           rom_addr,
	output wire                  rom_rd,
	output wire                  rom_wr,
	output wire [7:0]            rom_wdata
);
	localparam [1:0]  ST_IDLE = 2'h0;
	localparam [1:0]  ST_WAIT = 2'h1;
	localparam [1:0]  ST_ROM  = 2'h2;
	localparam [31:0] TO_FULL = TIMEOUT_CYCLES - 1;
	localparam [31:0] SH_FULL = DRAM_SIZE_LOG2;
	localparam [15:0] TO_LAST = TO_FULL[15:0];
	localparam [5:0]  DRAM_SH = SH_FULL[5:0];

	reg [1:0]          state_r;
	reg [`NUM_TGT-1:0] sel_r;
	reg [31:0]         addr_r;
	reg [15:0]         cnt_r;
	reg                ack_r;
	reg                tea_r;
	reg [31:0]         rdata_r;
	reg                alias_r;
	reg                fwe_r;
	reg                sz_start_r;
	reg                ecc_meta_r;
	reg                ecc_fit_r;
	reg                smz_meta_r;
	reg                smz_fit_r;
	reg [`NUM_TGT-1:0] dec;
	wire [31:0]        dram_mask;
	wire [31:0]        sram_mask;
	wire               width_err;
	wire               timed_out;
	wire               sz_done;
	wire [31:0]        sz_rdata;
	wire [1:0]         sz_off;

	function hit;
		input [31:0] a;
		input [31:0] base;
		input [31:0] mask;
		begin
			hit = ((a & mask) == base);
		end
	endfunction

	// ************************************************************
	// mezzanine presence straps come from off-chip
	// ************************************************************
	always @(posedge clk) begin
		if (!rst_b) begin
			ecc_meta_r <= 1'b0;
			ecc_fit_r  <= 1'b0;
			smz_meta_r <= 1'b0;
			smz_fit_r  <= 1'b0;
		end else begin
			ecc_meta_r <= ecc_mezz_fitted;
			ecc_fit_r  <= ecc_meta_r;
			smz_meta_r <= sram_mezz_fitted;
			smz_fit_r  <= smz_meta_r;
		end
	end

	// ************************************************************
	// address decode
	// ************************************************************
	assign dram_mask = ~((32'h0000_0001 << DRAM_SH) - 32'h0000_0001);
	assign sram_mask = smz_fit_r ? `MASK_2M : `MASK_128K; // RULE15

	// priority chain keeps the decode one-hot or all zero
	always @* begin
		dec = {`NUM_TGT{1'b0}};
		if (transfer_type_code == `TT_IACK)
			dec[`T_IACK] = 1'b1; // RULE2
		else if (alias_r && hit(bus_addr, `ALIAS_BASE, `MASK_2M))
			dec[`T_ROM_LOW_ALIAS_BIT] = 1'b1; // RULE3 RULE1
		else if (hit(bus_addr, `ROM_LOW_ALIAS_BIT_BASE, `MASK_2M))
			dec[`T_ROM_LOW_ALIAS_BIT] = 1'b1;
		else if (hit(bus_addr, `ROM1_BASE, `MASK_2M))
			dec[`T_ROM1] = 1'b1;
		else if (hit(bus_addr, `SRAM_DEF_BASE, `MASK_128K))
			dec[`T_SRAM] = ~smz_fit_r; // RULE15
		else if (bus_addr >= `IO_FIRST && bus_addr <= `IO_LAST) begin // RULE16
			// anything below not listed is reserved and never answers
			if (hit(bus_addr, `LOCAL_CONTROL_STATUS_SPACE_BASE, `MASK_256B))
				dec[`T_LOCAL_CONTROL_STATUS_SPACE] = 1'b1;
			else if (hit(bus_addr, `GLOBAL_CONTROL_STATUS_SPACE_BASE, `MASK_256B))
				dec[`T_GLOBAL_CONTROL_STATUS_SPACE] = 1'b1; // RULE10
			else if (hit(bus_addr, `CTRL_BASE, `MASK_4K))
				dec[`T_CTRL] = 1'b1;
			else if (hit(bus_addr, `ECC_BASE, `MASK_4K))
				dec[`T_ECC] = ecc_fit_r; // RULE8
			else if (hit(bus_addr, `SERIAL_BASE, `MASK_4K))
				dec[`T_SERIAL] = 1'b1;
			else if (hit(bus_addr, `LAN_BASE, `MASK_4K))
				dec[`T_LAN] = 1'b1;
			else if (hit(bus_addr, `SCSI_BASE, `MASK_4K))
				dec[`T_SCSI] = 1'b1;
			else if (hit(bus_addr, `CIO_BASE, `MASK_2K))
				dec[`T_CIO] = 1'b1;
			else if (hit(bus_addr, `CREG_BASE, `MASK_32B))
				dec[`T_CREG] = 1'b1;
			else if (hit(bus_addr, `BATTERY_BACKED_RAM_BASE, `MASK_64K))
				dec[`T_BATTERY_BACKED_RAM] = 1'b1; // RULE18
		end else if (hit(bus_addr, `VME16_BASE, `MASK_64K))
			dec[`T_VME16] = 1'b1;
		else if (sram_en && smz_fit_r && hit(bus_addr, sram_base & sram_mask, sram_mask))
			dec[`T_SRAM_MEZZ] = 1'b1; // RULE15
		else if (sram_en && hit(bus_addr, sram_base & sram_mask, sram_mask))
			dec[`T_SRAM] = 1'b1;
		else if (dram_en && hit(bus_addr, dram_base & dram_mask, dram_mask))
			dec[`T_DRAM] = 1'b1; // RULE6
	end

	// reads of either csr space and global csr writes pass at any width
	assign width_err = dec[`T_LOCAL_CONTROL_STATUS_SPACE] & ~bus_read & (bus_size != `SIZ_LONG); // RULE9 RULE10
	assign timed_out = bus_timer_en & (cnt_r == TO_LAST); // RULE6 RULE7

	// ************************************************************
	// cycle control
	// ************************************************************
	always @(posedge clk) begin
		if (!rst_b) begin
			state_r    <= ST_IDLE;
			sel_r      <= {`NUM_TGT{1'b0}};
			addr_r     <= 32'h0000_0000;
			cnt_r      <= 16'h0000;
			ack_r      <= 1'b0;
			tea_r      <= 1'b0;
			rdata_r    <= 32'h0000_0000;
			alias_r    <= `ALIAS_RST; // RULE4
			fwe_r      <= `FLASH_WE_RST;
			sz_start_r <= 1'b0;
		end else begin
			ack_r      <= 1'b0;
			tea_r      <= 1'b0;
			sz_start_r <= 1'b0;
			if (rom_alias_clear)
				alias_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (bus_start) begin
						addr_r <= bus_addr;
						cnt_r  <= 16'h0000;
						if (width_err) begin
							tea_r <= 1'b1; // RULE9
						end else begin
							sel_r <= dec; // RULE19
							if (dec[`T_BATTERY_BACKED_RAM] && bus_addr[15:14] == `BB_FWE_OFF)
								fwe_r <= 1'b0; // RULE18
							else if (dec[`T_BATTERY_BACKED_RAM] && bus_addr[15:14] == `BB_FWE_ON)
								fwe_r <= 1'b1; // RULE18
							if (dec[`T_ROM_LOW_ALIAS_BIT] | dec[`T_ROM1]) begin
								sz_start_r <= 1'b1; // RULE14
								state_r    <= ST_ROM;
							end else begin
								state_r <= ST_WAIT;
							end
						end
					end
				end
				ST_WAIT: begin
					// an empty select waits for the timer alone
					if ((|sel_r) && tgt_ack) begin
						ack_r   <= 1'b1;
						rdata_r <= tgt_rdata;
						sel_r   <= {`NUM_TGT{1'b0}}; // RULE19
						state_r <= ST_IDLE;
					end else if (timed_out) begin
						tea_r   <= 1'b1; // RULE6 RULE7 RULE8
						sel_r   <= {`NUM_TGT{1'b0}};
						state_r <= ST_IDLE;
					end else if (bus_timer_en) begin
						cnt_r <= cnt_r + 16'h0001;
					end
				end
				ST_ROM: begin
					if (sz_done) begin
						ack_r   <= 1'b1;
						rdata_r <= sz_rdata; // RULE14
						sel_r   <= {`NUM_TGT{1'b0}};
						state_r <= ST_IDLE;
					end else if (timed_out) begin
						tea_r   <= 1'b1;
						sel_r   <= {`NUM_TGT{1'b0}};
						state_r <= ST_IDLE;
					end else if (bus_timer_en) begin
						cnt_r <= cnt_r + 16'h0001;
					end
				end
				default: begin
					sel_r   <= {`NUM_TGT{1'b0}};
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// private byte bus for boot rom and flash
	// ************************************************************
	// flash writes outside the enable window finish without a strobe
	rom_byte_sizer u_sizer (
		.clk        (clk),
		.rst_b      (rst_b),
		.start      (sz_start_r),
		.abort      (state_r == ST_ROM && timed_out && !sz_done),
		.rd         (bus_read),
		.size       (bus_size),
		.offset     (addr_r[1:0]),
		.wdata      (bus_wdata),
		.wr_allow   (fwe_r),
		.priv_off   (sz_off),
		.priv_rd    (rom_rd),
		.priv_wr    (rom_wr),
		.priv_wdata (rom_wdata),
		.priv_rdata (rom_rdata),
		.priv_ack   (rom_byte_ack),
		.done       (sz_done),
		.rdata      (sz_rdata)
	);

	assign rom_addr           = {addr_r[31:2], sz_off};
	assign target_sel         = sel_r;
	assign bus_ack            = ack_r;
	assign transfer_error_ack = tea_r;
	assign bus_rdata          = rdata_r;
	assign rom_low_alias_bit  = alias_r;
	assign flash_write_en     = fwe_r;
endmodule

/* File: bus_decode_props.sv */
`timescale 1ns/100ps
`include "local_bus_consts.vh"
module bus_decode_props (
	input wire                clk,
	input wire                rst_b,
	input wire                bus_start,
	input wire [31:0]         bus_addr,
	input wire [1:0]          transfer_type_code,
	input wire                bus_read,
	input wire [1:0]          bus_size,
	input wire                ecc_mezz_fitted,
	input wire [`NUM_TGT-1:0] target_sel,
	input wire                bus_ack,
	input wire                transfer_error_ack,
	input wire                rom_low_alias_bit,
	input wire                flash_write_en
);
	// ****
	// access tracking: a new start is legal in the ack cycle
	// ****
	reg  busy_r;
	wire done = bus_ack || transfer_error_ack;
	wire take = bus_start && (!busy_r || done);
	wire norm = take && transfer_type_code <= `TT_NORMAL_LAST;
	always @(posedge clk) begin
		if (!rst_b)
			busy_r <= 1'b0;
		else if (take)
			busy_r <= 1'b1;
		else if (done)
			busy_r <= 1'b0;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_one_select: assert property ($onehot0(target_sel))
		else $error("two target selects at once");
	a_end_clear: assert property (done |-> target_sel == 0 && !(bus_ack && transfer_error_ack))
		else $error("select left up at termination");
	a_sel_hold: assert property (target_sel != 0 && !done |=> target_sel == $past(target_sel) || done)
		else $error("select dropped before termination");
	// reset itself is the cause here, so this one is never disabled
	a_alias_reset: assert property (disable iff (1'b0) !rst_b |=> rom_low_alias_bit)
		else $error("alias bit low after reset");
	a_alias_hit: assert property (norm && bus_addr[31:21] == 11'h000 && rom_low_alias_bit
		|=> target_sel[`T_ROM_LOW_ALIAS_BIT])
		else $error("low alias did not select boot block");
	a_iack_sel: assert property (take && transfer_type_code == `TT_IACK |=> target_sel[`T_IACK])
		else $error("iack cycle not selected");
	a_reserved_quiet: assert property (norm && bus_addr[31:18] == 14'h3FFC |=> target_sel == 0)
		else $error("reserved window selected");
	a_ecc_quiet: assert property (norm && (bus_addr & `MASK_4K) == `ECC_BASE && !ecc_mezz_fitted
		|=> target_sel == 0)
		else $error("ecc window selected without mezzanine");
	a_local_control_status_space_narrow: assert property (norm && (bus_addr & `MASK_256B) == `LOCAL_CONTROL_STATUS_SPACE_BASE && !bus_read
		&& (bus_size == `SIZ_BYTE || bus_size == `SIZ_WORD) |=> transfer_error_ack)
		else $error("narrow local csr write not refused");
	a_flash_block: assert property (norm && bus_addr[31:14] == 18'h3_FFF2 |=> !flash_write_en)
		else $error("flash writes not disabled");
	a_flash_allow: assert property (norm && bus_addr[31:14] == 18'h3_FFF3 |=> flash_write_en)
		else $error("flash writes not enabled");
	cover property (norm && bus_addr[31:21] == 11'h000 ##1 target_sel[`T_ROM_LOW_ALIAS_BIT]);
	cover property (transfer_error_ack);
	cover property (take && transfer_type_code == `TT_IACK);
endmodule
bind local_bus_address_decoder bus_decode_props props_u (.clk(clk), .rst_b(rst_b),
	.bus_start(bus_start), .bus_addr(bus_addr), .transfer_type_code(transfer_type_code),
	.bus_read(bus_read), .bus_size(bus_size), .ecc_mezz_fitted(ecc_mezz_fitted),
	.target_sel(target_sel), .bus_ack(bus_ack), .transfer_error_ack(transfer_error_ack),
	.rom_low_alias_bit(rom_low_alias_bit), .flash_write_en(flash_write_en));

/* File: far_target_model.sv */
`timescale 1ns/100ps
`include "local_bus_consts.vh"
module far_target_model (
	input  wire                clk,
	input  wire                rst_b,
	input  wire [`NUM_TGT-1:0] target_sel,
	input  wire [31:0]         rom_addr,
	input  wire                rom_rd,
	input  wire                rom_wr,
	input  wire [3:0]          wait_cycles,
	output reg                 tgt_ack,
	output wire [31:0]         tgt_rdata,
	output wire [7:0]          rom_rdata,
	output reg                 rom_byte_ack,
	input  wire [7:0]          rom_wdata,
	output reg  [31:0]         wr_log
);
	// ****
	// all targets but the two boot roms answer only while selected, after wait_cycles
	// ****
	reg  [3:0] cnt_r;
	wire       sel_any = |target_sel[`NUM_TGT-1:2];
	wire [7:0] rom_byte = 8'hA0 + {6'h00, rom_addr[1:0]};
	// data lines show garbage outside the acknowledge cycle
	assign tgt_rdata = tgt_ack ? 32'hC0DE_0042 : 32'h3F21_FFBD;
	assign rom_rdata = rom_byte_ack ? rom_byte : ~rom_byte;
	always @(posedge clk) begin
		if (!rst_b || !sel_any) begin
			cnt_r   <= 4'h0;
			tgt_ack <= 1'b0;
		end else if (tgt_ack)
			tgt_ack <= 1'b0;
		else if (cnt_r == wait_cycles)
			tgt_ack <= 1'b1;
		else
			cnt_r <= cnt_r + 4'h1;
	end
	always @(posedge clk)
		rom_byte_ack <= rst_b && (rom_rd || rom_wr) && !rom_byte_ack;
	// bytes shift in as they land, so a long write reads back as one big-endian word
	always @(posedge clk)
		if (!rst_b)
			wr_log <= 32'h0000_0000;
		else if (rom_wr && !rom_byte_ack)
			wr_log <= {wr_log[23:0], rom_wdata};
endmodule

/* File: local_bus_address_decoder_bench.sv */
`timescale 1ns/100ps
`include "local_bus_consts.vh"
module local_bus_address_decoder_bench;
	reg                 clk, rst_b, bus_start, bus_read, bus_timer_en, dram_en, sram_en;
	reg                 rom_alias_clear, ecc_mezz_fitted, sram_mezz_fitted;
	reg  [31:0]         bus_addr, bus_wdata, dram_base, sram_base;
	reg  [1:0]          transfer_type_code, bus_size;
	reg  [3:0]          wait_cycles;
	wire [`NUM_TGT-1:0] target_sel;
	wire [31:0]         bus_rdata, tgt_rdata, rom_addr, wr_log;
	wire [7:0]          rom_rdata, rom_wdata;
	wire                bus_ack, transfer_error_ack, rom_low_alias_bit, flash_write_en;
	wire                tgt_ack, rom_byte_ack, rom_rd, rom_wr;
	integer             n_fail, check_count, cyc, i;
	local_bus_address_decoder #(.TIMEOUT_CYCLES(24)) dut_u (.clk(clk), .rst_b(rst_b),
		.bus_start(bus_start), .bus_addr(bus_addr), .transfer_type_code(transfer_type_code),
		.bus_read(bus_read), .bus_size(bus_size), .bus_wdata(bus_wdata),
		.bus_timer_en(bus_timer_en), .dram_base(dram_base), .dram_en(dram_en),
		.sram_base(sram_base), .sram_en(sram_en), .rom_alias_clear(rom_alias_clear),
		.ecc_mezz_fitted(ecc_mezz_fitted), .sram_mezz_fitted(sram_mezz_fitted),
		.tgt_ack(tgt_ack), .tgt_rdata(tgt_rdata), .rom_rdata(rom_rdata),
		.rom_byte_ack(rom_byte_ack), .target_sel(target_sel), .bus_ack(bus_ack),
		.transfer_error_ack(transfer_error_ack), .bus_rdata(bus_rdata),
		.rom_low_alias_bit(rom_low_alias_bit), .flash_write_en(flash_write_en),
		.rom_addr(rom_addr), .rom_rd(rom_rd), .rom_wr(rom_wr), .rom_wdata(rom_wdata));
	far_target_model tgt_u (.clk(clk), .rst_b(rst_b), .target_sel(target_sel),
		.rom_addr(rom_addr), .rom_rd(rom_rd), .rom_wr(rom_wr), .wait_cycles(wait_cycles),
		.tgt_ack(tgt_ack), .tgt_rdata(tgt_rdata), .rom_rdata(rom_rdata),
		.rom_byte_ack(rom_byte_ack), .rom_wdata(rom_wdata), .wr_log(wr_log));
	// ****
	// helpers
	// ****
	always #50 clk = ~clk;
	task report_and_stop;
		begin
			$display("checks %0d, mismatches %0d", check_count, n_fail);
			if (n_fail == 0 && check_count > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			n_fail = n_fail + 1;
			report_and_stop;
		end
	end
	task chk(input [31:0] got, input [31:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("Error at %0t: got %h, expected %h", $time, got, exp);
			end
		end
	endtask
	task do_reset;
		begin
			rst_b = 1'b0;
			repeat (5) @(negedge clk);
			rst_b = 1'b1;
		end
	endtask
	task settle;
		repeat (3) @(negedge clk);
	endtask
	// one access; idx < 0 means no target may be selected
	task acc(input [31:0] a, input [1:0] tt, input rd, input [1:0] sz, input err,
		input integer idx, input [31:0] exp);
		integer             n;
		reg [`NUM_TGT-1:0] seen;
		begin
			bus_addr = a;
			transfer_type_code = tt;
			bus_read = rd;
			bus_size = sz;
			bus_start = 1'b1;
			@(negedge clk);
			bus_start = 1'b0;
			seen = 0;
			n = 0;
			while (!(bus_ack || transfer_error_ack) && n < 60) begin
				seen = seen | target_sel;
				@(negedge clk);
				n = n + 1;
			end
			chk({31'h0, transfer_error_ack}, {31'h0, err});
			chk({31'h0, bus_ack}, {31'h0, ~err});
			chk({15'h0, seen}, idx < 0 ? 32'h0 : 32'h1 << idx);
			if (rd && !err)
				chk(bus_rdata, exp);
			@(negedge clk);
		end
	endtask
	// ****
	// scenarios
	// ****
	task t_alias;
		begin
			chk({31'h0, rom_low_alias_bit}, 32'h1);
			chk({31'h0, flash_write_en}, 32'h0);
			for (i = 0; i < 3; i = i + 1)
				acc(32'h0000_0010, i, 1, `SIZ_LONG, 0, `T_ROM_LOW_ALIAS_BIT, 32'hA0A1_A2A3);
			acc(32'h0000_0000, `TT_IACK, 1, `SIZ_LONG, 0, `T_IACK, 32'hC0DE_0042);
			acc(32'hFFA0_0003, 0, 1, `SIZ_BYTE, 0, `T_ROM1, 32'h0000_00A3);
		end
	endtask
	task t_refused;
		begin
			acc(32'hFFF0_0000, 0, 1, `SIZ_LONG, 1, -1, 0);
			acc(32'hFFC0_0000, 0, 1, `SIZ_LONG, 1, -1, 0);
			acc(`ECC_BASE, 0, 1, `SIZ_BYTE, 1, -1, 0);
			acc(`LOCAL_CONTROL_STATUS_SPACE_BASE, 0, 0, `SIZ_BYTE, 1, -1, 0);
			acc(`LOCAL_CONTROL_STATUS_SPACE_BASE, 0, 0, `SIZ_WORD, 1, -1, 0);
		end
	endtask
	// with the timer off a reserved access hangs; enabling it ends the access
	task t_timer;
		begin
			bus_timer_en = 1'b0;
			bus_addr = 32'hFFF0_0000;
			bus_start = 1'b1;
			@(negedge clk);
			bus_start = 1'b0;
			i = 0;
			repeat (40) begin
				i = i + (bus_ack | transfer_error_ack);
				@(negedge clk);
			end
			chk(i, 0);
			bus_timer_en = 1'b1;
			repeat (24) @(negedge clk);
			chk({31'h0, transfer_error_ack}, 32'h1);
			@(negedge clk);
		end
	endtask
	task t_widths;
		begin
			acc(`LOCAL_CONTROL_STATUS_SPACE_BASE, 0, 0, `SIZ_LONG, 0, `T_LOCAL_CONTROL_STATUS_SPACE, 0);
			acc(`LOCAL_CONTROL_STATUS_SPACE_BASE, 0, 1, `SIZ_BYTE, 0, `T_LOCAL_CONTROL_STATUS_SPACE, 32'hC0DE_0042);
			acc(`GLOBAL_CONTROL_STATUS_SPACE_BASE, 0, 0, `SIZ_BYTE, 0, `T_GLOBAL_CONTROL_STATUS_SPACE, 0);
			acc(`GLOBAL_CONTROL_STATUS_SPACE_BASE, 0, 0, `SIZ_WORD, 0, `T_GLOBAL_CONTROL_STATUS_SPACE, 0);
			acc(32'hFFF4_5001, 0, 1, `SIZ_BYTE, 0, `T_SERIAL, 32'hC0DE_0042);
			acc(`LAN_BASE, 0, 0, `SIZ_WORD, 0, `T_LAN, 0);
			acc(32'hFFF4_6002, 0, 0, `SIZ_WORD, 0, `T_LAN, 0);
			acc(`GLOBAL_CONTROL_STATUS_SPACE_BASE, 0, 1, `SIZ_BYTE, 0, `T_GLOBAL_CONTROL_STATUS_SPACE, 32'hC0DE_0042);
			acc(`CTRL_BASE, 0, 1, `SIZ_LONG, 0, `T_CTRL, 32'hC0DE_0042);
			acc(`SCSI_BASE, 0, 1, `SIZ_BYTE, 0, `T_SCSI, 32'hC0DE_0042);
			acc(`CIO_BASE, 0, 1, `SIZ_WORD, 0, `T_CIO, 32'hC0DE_0042);
			acc(`CREG_BASE, 0, 1, `SIZ_BYTE, 0, `T_CREG, 32'hC0DE_0042);
			acc(`VME16_BASE, 0, 1, `SIZ_WORD, 0, `T_VME16, 32'hC0DE_0042);
		end
	endtask
	task t_mezz;
		begin
			wait_cycles = 4'h3;
			ecc_mezz_fitted = 1'b1;
			sram_mezz_fitted = 1'b1;
			settle;
			acc(`ECC_BASE, 0, 1, `SIZ_BYTE, 0, `T_ECC, 32'hC0DE_0042);
			acc(`SRAM_DEF_BASE, 0, 1, `SIZ_LONG, 1, -1, 0);
			acc(32'h011F_FFFC, 0, 1, `SIZ_LONG, 0, `T_SRAM_MEZZ, 32'hC0DE_0042);
			sram_mezz_fitted = 1'b0;
			settle;
			acc(32'h0100_0000, 0, 0, `SIZ_LONG, 0, `T_SRAM, 0);
			acc(32'h0102_0000, 0, 0, `SIZ_LONG, 1, -1, 0);
			acc(`SRAM_DEF_BASE, 0, 0, `SIZ_LONG, 0, `T_SRAM, 0);
			wait_cycles = 4'h0;
		end
	endtask
	task t_flash;
		begin
			acc(32'hFFFC_C000, 0, 1, `SIZ_BYTE, 0, `T_BATTERY_BACKED_RAM, 32'hC0DE_0042);
			chk({31'h0, flash_write_en}, 32'h1);
			acc(`ROM_LOW_ALIAS_BIT_BASE, 0, 0, `SIZ_LONG, 0, `T_ROM_LOW_ALIAS_BIT, 0);
			chk(wr_log, 32'h1234_5678);
			acc(32'hFFFC_8000, 0, 0, `SIZ_BYTE, 0, `T_BATTERY_BACKED_RAM, 0);
			chk({31'h0, flash_write_en}, 32'h0);
			bus_wdata = 32'h9ABC_DEF0;
			acc(`ROM_LOW_ALIAS_BIT_BASE, 0, 0, `SIZ_LONG, 0, `T_ROM_LOW_ALIAS_BIT, 0);
			chk(wr_log, 32'h1234_5678);
		end
	endtask
	task t_clear;
		begin
			rom_alias_clear = 1'b1;
			@(negedge clk);
			rom_alias_clear = 1'b0;
			@(negedge clk);
			chk({31'h0, rom_low_alias_bit}, 32'h0);
			acc(32'h0000_0010, 0, 1, `SIZ_LONG, 0, `T_DRAM, 32'hC0DE_0042);
			do_reset;
			chk({31'h0, rom_low_alias_bit}, 32'h1);
			acc(32'h0000_0010, 0, 1, `SIZ_LONG, 0, `T_ROM_LOW_ALIAS_BIT, 32'hA0A1_A2A3);
		end
	endtask
	initial begin
		{clk, rst_b, bus_start, bus_read, rom_alias_clear} = 5'h00;
		{ecc_mezz_fitted, sram_mezz_fitted, bus_size, transfer_type_code} = 6'h00;
		{bus_timer_en, dram_en, sram_en} = 3'h7;
		{bus_addr, dram_base} = 64'h0;
		bus_wdata = 32'h1234_5678;
		sram_base = 32'h0100_0000;
		wait_cycles = 4'h0;
		{n_fail, check_count, cyc} = 0;
		do_reset;
		t_alias;
		t_refused;
		t_timer;
		t_widths;
		t_mezz;
		t_flash;
		t_clear;
		report_and_stop;
	end
endmodule
